//--- rtm_pkg.sv
// constants shared by the radio test mode command handler
`default_nettype none
package rtm_pkg;
    // frame layout
    localparam logic [7:0] START_BYTE = 8'h02;
    localparam logic [7:0] CMD_ENTER_REQ = 8'h1D;
    localparam logic [7:0] CMD_ENTER_CNF = 8'h5D;
    localparam logic [7:0] CMD_CTRL_REQ = 8'h1E;
    localparam logic [7:0] CMD_CTRL_CNF = 8'h5E;
    localparam logic [7:0] CMD_STATE_CNF = 8'h41;
    localparam logic [15:0] ENTER_LEN = 16'h0000;
    localparam logic [15:0] CTRL_LEN = 16'h0004;
    localparam logic [2:0] PAY_MAX = 3'h4;
    localparam logic [2:0] CNT_SHORT = 3'h1;
    localparam logic [2:0] CNT_RESULT = 3'h3;
    // test control command codes and sub fields
    localparam logic [7:0] CC_SETUP = 8'h00;
    localparam logic [7:0] CC_RX = 8'h01;
    localparam logic [7:0] CC_TX = 8'h02;
    localparam logic [7:0] CC_STOP = 8'h03;
    localparam logic [7:0] VOPT_RESET = 8'h00;
    localparam logic [7:0] VOPT_PHY = 8'h02;
    localparam logic [7:0] PHY_1M = 8'h01;
    localparam logic [7:0] PHY_2M = 8'h02;
    localparam logic [7:0] PAT_55 = 8'h02;
    localparam logic [7:0] PAY_VENDOR = 8'h03;
    localparam logic [7:0] VCMD_CARRIER = 8'h00;
    localparam logic [7:0] VCMD_POWER = 8'h02;
    // status and result values
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_FAIL = 8'h01;
    localparam logic [7:0] ST_BUSY = 8'h03;
    localparam logic [7:0] ST_DENIED = 8'hFF;
    localparam logic [15:0] RES_OK = 16'h0000;
    localparam logic [15:0] RES_FAIL = 16'h0001;
    localparam logic [15:0] RES_RX_FLAG = 16'h8000;
    // state report contents
    localparam logic [7:0] ROLE_TEST = 8'h10;
    localparam logic [7:0] ACTION_TEST = 8'h05;
    localparam logic [7:0] INFO_RESERVED = 8'h00;
    // radio settings
    localparam logic [7:0] CH_MAX = 8'h27;
    localparam logic [11:0] FREQ_BASE = 12'h962;
    localparam logic [7:0] PWR_DEFAULT = 8'h08;
    localparam logic [7:0] PWR_MIN = 8'hD8;
    localparam logic [7:0] PWR_MAX_SET = 8'h04;
endpackage : rtm_pkg
`default_nettype wire

//--- rtm_frame_if.sv
// request from the command handler to the confirmation frame sender
`default_nettype none
interface rtm_frame_if;
    logic start;
    logic busy;
    logic [7:0] cmd;
    logic [2:0] count;
    logic [7:0] pay [4];
    modport src (output start, output cmd, output count, output pay, input busy);
    modport snk (input start, input cmd, input count, input pay, output busy);
endinterface : rtm_frame_if
`default_nettype wire

//--- rtm_frame_tx.sv
// confirmation frame sender: start byte, command, length, payload, checksum
`default_nettype none
module rtm_frame_tx (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // frame request
    rtm_frame_if.snk frm,
    // byte stream to the host
    output logic [7:0] tx_byte_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in
);
    logic [7:0] cs_q;
    logic [2:0] idx_q;
    logic [2:0] cnt_q;
    logic [7:0] pay_q [4];
    logic [7:0] cmd_q;
    logic [7:0] cs_d;
    logic [7:0] nxt_d;
    logic last_d;

    assign frm.busy = tx_valid_out;

    ////////////////////////////////////////////////////////////////////////
    // next byte after the one now on the port; idx_q counts sent bytes
    always_comb begin
        cs_d = cs_q ^ tx_byte_out;
        last_d = (idx_q == cnt_q + 3'h4);
        if (idx_q == 3'h0) begin
            nxt_d = cmd_q;
        end else if (idx_q == 3'h1) begin
            nxt_d = {5'h00, cnt_q};
        end else if (idx_q == 3'h2) begin
            nxt_d = 8'h00;
        end else if (idx_q < cnt_q + 3'h3) begin
            nxt_d = pay_q[2'(idx_q - 3'h3)];
        end else begin
            nxt_d = cs_d;
        end
    end

    // fields are copied at start so the handler may move on at once
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_valid_out <= 1'b0;
            tx_byte_out <= 8'h00;
            idx_q <= 3'h0;
            cs_q <= 8'h00;
            cnt_q <= 3'h0;
            cmd_q <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                pay_q[i] <= 8'h00;
            end
        end else if (!tx_valid_out) begin
            if (frm.start) begin
                tx_valid_out <= 1'b1;
                tx_byte_out <= rtm_pkg::START_BYTE;
                idx_q <= 3'h0;
                cs_q <= 8'h00;
                cnt_q <= frm.count;
                cmd_q <= frm.cmd;
                pay_q <= frm.pay;
            end
        end else if (tx_ready_in) begin
            cs_q <= cs_d;
            idx_q <= idx_q + 3'h1;
            tx_byte_out <= nxt_d;
            if (last_d) begin
                tx_valid_out <= 1'b0; // checksum taken: frame over
            end
        end
    end

    frame_head_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (frm.start && !tx_valid_out) |=> tx_valid_out && tx_byte_out == rtm_pkg::START_BYTE)
        else $error("frame does not open with the start byte");
endmodule : rtm_frame_tx
`default_nettype wire

//--- rtm_handler.sv
// radio test mode command handler: request parser, decoder and settings
`default_nettype none
module rtm_handler (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // request bytes from the host port
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_valid_in,
    output logic rx_ready_out,
    // confirmation bytes to the host port
    output logic [7:0] tx_byte_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    // radio side
    input wire logic [14:0] rx_count_in,
    output logic test_mode_out,
    output logic rx_test_out,
    output logic tx_test_out,
    output logic carrier_test_out,
    output logic [5:0] channel_out,
    output logic [11:0] freq_mhz_out,
    output logic [7:0] tx_len_out,
    output logic [1:0] pattern_out,
    output logic [7:0] tx_power_out,
    output logic phy_2m_out
);
    typedef enum {S_START, S_CMD, S_LEN0, S_LEN1, S_PAY, S_SUM, S_EXEC, S_SEND, S_WAIT}
        rtm_state_e;
    rtm_state_e state_q;
    logic [7:0] cmd_q, cs_q, fcmd_q, cnf_d, st_d;
    logic [15:0] len_q, rem_q, res_d;
    logic [2:0] pidx_q, fcnt_q, n_d;
    logic [7:0] pay_q [4], fpay_q [4];
    logic report_q, start_q, take, running, ch_ok, pwr_ok;
    logic enter_d, srst_d, phy_d, rx_d, tx_d, car_d, pwr_d, stop_d;
    rtm_frame_if frm ();
    assign take = rx_valid_in && rx_ready_out;
    assign running = rx_test_out || tx_test_out || carrier_test_out;
    assign ch_ok = pay_q[1] <= rtm_pkg::CH_MAX;
    assign pwr_ok = $signed(pay_q[1]) >= $signed(rtm_pkg::PWR_MIN)
        && $signed(pay_q[1]) <= $signed(rtm_pkg::PWR_MAX_SET);
    assign frm.start = start_q;
    assign frm.cmd = fcmd_q;
    assign frm.count = fcnt_q;
    assign frm.pay = fpay_q;
    ////////////////////////////////////////////////////////////////////////
    // request parser and confirmation sequencing
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= S_START;
            rx_ready_out <= 1'b1;
            cmd_q <= 8'h00;
            cs_q <= 8'h00;
            len_q <= 16'h0000;
            rem_q <= 16'h0000;
            pidx_q <= 3'h0;
            report_q <= 1'b0;
            start_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                pay_q[i] <= 8'h00;
            end
        end else begin
            start_q <= 1'b0;
            if (take) begin
                cs_q <= cs_q ^ rx_byte_in;
            end
            unique case (state_q)
                S_START: if (take && rx_byte_in == rtm_pkg::START_BYTE) begin
                    cs_q <= rtm_pkg::START_BYTE;
                    state_q <= S_CMD;
                end
                S_CMD: if (take) begin
                    cmd_q <= rx_byte_in;
                    state_q <= S_LEN0;
                end
                S_LEN0: if (take) begin
                    len_q[7:0] <= rx_byte_in;
                    state_q <= S_LEN1;
                end
                S_LEN1: if (take) begin
                    len_q[15:8] <= rx_byte_in;
                    rem_q <= {rx_byte_in, len_q[7:0]};
                    pidx_q <= 3'h0;
                    state_q <= ({rx_byte_in, len_q[7:0]} == 16'h0000) ? S_SUM : S_PAY;
                end
                // bytes past the fourth are counted and folded into the sum only
                S_PAY: if (take) begin
                    if (pidx_q < rtm_pkg::PAY_MAX) begin
                        pay_q[2'(pidx_q)] <= rx_byte_in;
                        pidx_q <= pidx_q + 3'h1;
                    end
                    rem_q <= rem_q - 16'h0001;
                    if (rem_q == 16'h0001) begin
                        state_q <= S_SUM;
                    end
                end
                // other command groups are not ours: their frames are dropped
                S_SUM: if (take) begin
                    if (rx_byte_in == cs_q && (cmd_q == rtm_pkg::CMD_ENTER_REQ
                        || cmd_q == rtm_pkg::CMD_CTRL_REQ)) begin
                        rx_ready_out <= 1'b0;
                        state_q <= S_EXEC;
                    end else begin
                        state_q <= S_START;
                    end
                end
                S_EXEC: begin
                    report_q <= enter_d;
                    state_q <= S_SEND;
                end
                S_SEND: if (!frm.busy) begin
                    start_q <= 1'b1;
                    state_q <= S_WAIT;
                end
                S_WAIT: if (!frm.busy && !start_q) begin
                    if (report_q) begin
                        report_q <= 1'b0;
                        state_q <= S_SEND;
                    end else begin
                        rx_ready_out <= 1'b1;
                        state_q <= S_START;
                    end
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // decode of a checked request into status, result and setting actions
    always_comb begin
        cnf_d = rtm_pkg::CMD_CTRL_CNF;
        st_d = rtm_pkg::ST_OK;
        res_d = rtm_pkg::RES_OK;
        n_d = rtm_pkg::CNT_RESULT;
        {enter_d, srst_d, phy_d, rx_d, tx_d, car_d, pwr_d, stop_d} = 8'h00;
        if (cmd_q == rtm_pkg::CMD_ENTER_REQ) begin
            cnf_d = rtm_pkg::CMD_ENTER_CNF;
            n_d = rtm_pkg::CNT_SHORT;
            if (test_mode_out) begin
                st_d = rtm_pkg::ST_DENIED;
            end else if (len_q != rtm_pkg::ENTER_LEN) begin
                st_d = rtm_pkg::ST_FAIL;
            end else begin
                enter_d = 1'b1;
            end
        end else if (!test_mode_out) begin
            st_d = rtm_pkg::ST_DENIED;
            n_d = rtm_pkg::CNT_SHORT;
        end else if (len_q != rtm_pkg::CTRL_LEN) begin
            st_d = rtm_pkg::ST_FAIL;
            n_d = rtm_pkg::CNT_SHORT;
        end else begin
            case (pay_q[0])
                rtm_pkg::CC_SETUP: begin
                    if (pay_q[1] == rtm_pkg::VOPT_RESET) begin
                        srst_d = 1'b1;
                    end else if (pay_q[1] != rtm_pkg::VOPT_PHY
                        || (pay_q[2] != rtm_pkg::PHY_1M && pay_q[2] != rtm_pkg::PHY_2M)) begin
                        res_d = rtm_pkg::RES_FAIL;
                    end else if (running) begin
                        st_d = rtm_pkg::ST_BUSY;
                        n_d = rtm_pkg::CNT_SHORT;
                    end else begin
                        phy_d = 1'b1;
                    end
                end
                rtm_pkg::CC_RX: begin
                    if (running) begin
                        st_d = rtm_pkg::ST_BUSY;
                        n_d = rtm_pkg::CNT_SHORT;
                    end else if (!ch_ok) begin
                        res_d = rtm_pkg::RES_FAIL;
                    end else begin
                        rx_d = 1'b1;
                    end
                end
                rtm_pkg::CC_TX: begin
                    if (pay_q[3] == rtm_pkg::PAY_VENDOR && pay_q[2] == rtm_pkg::VCMD_POWER) begin
                        pwr_d = pwr_ok;
                        res_d = pwr_ok ? rtm_pkg::RES_OK : rtm_pkg::RES_FAIL;
                    end else if (running) begin
                        st_d = rtm_pkg::ST_BUSY;
                        n_d = rtm_pkg::CNT_SHORT;
                    end else if (!ch_ok) begin
                        res_d = rtm_pkg::RES_FAIL;
                    end else if (pay_q[3] == rtm_pkg::PAY_VENDOR
                        && pay_q[2] == rtm_pkg::VCMD_CARRIER) begin
                        car_d = 1'b1;
                    end else if (pay_q[3] <= rtm_pkg::PAT_55) begin
                        tx_d = 1'b1;
                    end else begin
                        res_d = rtm_pkg::RES_FAIL;
                    end
                end
                rtm_pkg::CC_STOP: begin
                    stop_d = 1'b1;
                    res_d = rtm_pkg::RES_RX_FLAG + (rx_test_out ? {1'b0, rx_count_in}
                        : 16'h0000);
                end
                default: res_d = rtm_pkg::RES_FAIL;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // confirmation and state report frame contents
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fcmd_q <= 8'h00;
            fcnt_q <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                fpay_q[i] <= 8'h00;
            end
        end else if (state_q == S_EXEC) begin
            fcmd_q <= cnf_d;
            fcnt_q <= n_d;
            fpay_q[0] <= st_d;
            fpay_q[1] <= res_d[15:8];
            fpay_q[2] <= res_d[7:0];
        end else if (state_q == S_WAIT && report_q && !frm.busy && !start_q) begin
            fcmd_q <= rtm_pkg::CMD_STATE_CNF;
            fcnt_q <= rtm_pkg::CNT_RESULT;
            fpay_q[0] <= rtm_pkg::ROLE_TEST;
            fpay_q[1] <= rtm_pkg::ACTION_TEST;
            fpay_q[2] <= rtm_pkg::INFO_RESERVED;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // radio settings; the async reset drops test mode, back to idle
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            test_mode_out <= 1'b0;
            {rx_test_out, tx_test_out, carrier_test_out} <= 3'h0;
            channel_out <= 6'h00;
            freq_mhz_out <= rtm_pkg::FREQ_BASE;
            tx_len_out <= 8'h00;
            pattern_out <= 2'h0;
            tx_power_out <= rtm_pkg::PWR_DEFAULT;
            phy_2m_out <= 1'b0;
        end else if (state_q == S_EXEC) begin
            if (enter_d || srst_d) begin
                test_mode_out <= 1'b1;
                {rx_test_out, tx_test_out, carrier_test_out} <= 3'h0;
                tx_power_out <= rtm_pkg::PWR_DEFAULT;
                phy_2m_out <= 1'b0;
            end
            if (phy_d) begin
                phy_2m_out <= pay_q[2] == rtm_pkg::PHY_2M;
            end
            if (rx_d || tx_d || car_d) begin
                rx_test_out <= rx_d;
                tx_test_out <= tx_d;
                carrier_test_out <= car_d;
                channel_out <= pay_q[1][5:0];
                freq_mhz_out <= rtm_pkg::FREQ_BASE + {5'h00, pay_q[1][5:0], 1'b0};
            end
            if (tx_d) begin
                tx_len_out <= pay_q[2];
                pattern_out <= pay_q[3][1:0];
            end
            if (pwr_d) begin
                tx_power_out <= pay_q[1];
            end
            if (stop_d) begin
                {rx_test_out, tx_test_out, carrier_test_out} <= 3'h0;
            end
        end
    end
    rtm_frame_tx u_tx (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .frm(frm),
        .tx_byte_out(tx_byte_out),
        .tx_valid_out(tx_valid_out),
        .tx_ready_in(tx_ready_in)
    );
    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence enter_taken;
        state_q == S_EXEC && enter_d;
    endsequence
    sequence report_sent;
        start_q && fcmd_q == rtm_pkg::CMD_STATE_CNF && fpay_q[0] == rtm_pkg::ROLE_TEST
            && fpay_q[1] == rtm_pkg::ACTION_TEST;
    endsequence
    enter_mode_a: assert property (enter_taken |=> test_mode_out
        && tx_power_out == rtm_pkg::PWR_DEFAULT && fcmd_q == rtm_pkg::CMD_ENTER_CNF)
        else $error("enter request did not enter test mode");
    state_report_a: assert property (enter_taken |=> ##[1:60] report_sent)
        else $error("no state report after entering test mode");
    deny_ctrl_a: assert property (state_q == S_EXEC && cmd_q == rtm_pkg::CMD_CTRL_REQ
        && !test_mode_out |=> fpay_q[0] == rtm_pkg::ST_DENIED && fcnt_q == 3'h1)
        else $error("control request outside test mode not refused");
    busy_start_a: assert property (state_q == S_EXEC && cmd_q == rtm_pkg::CMD_CTRL_REQ
        && test_mode_out && running && len_q == rtm_pkg::CTRL_LEN && (pay_q[0] == rtm_pkg::CC_RX
        || pay_q[0] == rtm_pkg::CC_TX && pay_q[3] != rtm_pkg::PAY_VENDOR)
        |=> fpay_q[0] == rtm_pkg::ST_BUSY && fcnt_q == rtm_pkg::CNT_SHORT && $stable(channel_out))
        else $error("test started while another runs");
    freq_map_a: assert property ($rose(rx_test_out) |-> freq_mhz_out
        == rtm_pkg::FREQ_BASE + {5'h00, channel_out, 1'b0} && channel_out <= 6'h27)
        else $error("channel frequency mismatch");
    stop_result_a: assert property (state_q == S_EXEC && stop_d |=> !running
        && fpay_q[1][7] && fpay_q[0] == rtm_pkg::ST_OK)
        else $error("stop did not clear test or flag result");
    power_range_a: assert property ($changed(tx_power_out) |->
        $signed(tx_power_out) >= $signed(rtm_pkg::PWR_MIN)
        && $signed(tx_power_out) <= $signed(rtm_pkg::PWR_DEFAULT))
        else $error("transmit power out of range");
    bad_sum_a: assert property (state_q == S_SUM && take && rx_byte_in != cs_q
        |=> state_q == S_START ##1 !start_q)
        else $error("frame with wrong checksum not discarded");
endmodule : rtm_handler
`default_nettype wire

//--- rtm_handler_note_end.sv
// intentionally empty companion: no logic
`default_nettype none
`default_nettype wire

//--- rtm_host.sv
// host model: sends request frames and takes reply bytes with random stalls
`default_nettype none
module rtm_host (
    // clock and stall control
    input wire logic clock_in,
    input wire logic slow_in,
    // request bytes to the handler
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    // reply bytes from the handler
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got [$];
    logic [7:0] lf_q = 8'hA5;
    initial rx_valid_out = 1'b0;
    initial rx_byte_out = 8'h00;
    initial tx_ready_out = 1'b1;
    ////////////////////////////////////////
    // stall pattern changes on the falling edge only
    always @(negedge clock_in) begin
        lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
        tx_ready_out <= !slow_in || lf_q[0];
    end
    // reads here see pre-edge values, as the design updates by nba
    always @(posedge clock_in) begin
        if (tx_valid_in && tx_ready_out) got.push_back(tx_byte_in);
    end
    // a byte stands until an edge with ready high; a released line shows its inverse
    task automatic send(input logic [7:0] b [$], output bit ok);
        bit r;
        int w;
        ok = 1'b1;
        foreach (b[i]) begin
            @(negedge clock_in);
            rx_byte_out = b[i];
            rx_valid_out = 1'b1;
            w = 0;
            do begin
                r = rx_ready_in;
                @(posedge clock_in);
                if (!r) @(negedge clock_in);
                w++;
            end while (!r && w < 300);
            ok &= r;
        end
        @(negedge clock_in);
        rx_valid_out = 1'b0;
        rx_byte_out = ~rx_byte_out;
    endtask : send
endmodule : rtm_host
`default_nettype wire

//--- tb.sv
// self-checking bench for the radio test mode command handler
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in, nrst_in, rx_valid, rx_ready, tx_valid, tx_ready, slow;
    logic test_mode, rx_test, tx_test, carrier, phy_2m;
    logic [7:0] rx_byte, tx_byte, tx_len, power, ch, ln;
    logic [14:0] rx_count;
    logic [5:0] channel;
    logic [11:0] freq;
    logic [1:0] pattern;
    logic [31:0] seed = 32'h852825AB;
    int bad_count, cmp_count, tn, k;
    rtm_handler rtm_handler_i (.clock_in(clock_in), .nrst_in(nrst_in), .rx_byte_in(rx_byte),
        .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .tx_byte_out(tx_byte),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .rx_count_in(rx_count),
        .test_mode_out(test_mode), .rx_test_out(rx_test), .tx_test_out(tx_test),
        .carrier_test_out(carrier), .channel_out(channel), .freq_mhz_out(freq),
        .tx_len_out(tx_len), .pattern_out(pattern), .tx_power_out(power), .phy_2m_out(phy_2m));
    rtm_host rtm_host_i (.clock_in(clock_in), .slow_in(slow), .rx_byte_out(rx_byte),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .tx_byte_in(tx_byte),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
    ////////////////////////////////////////
    // 10 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // xor of all bytes from a start index
    function automatic logic [7:0] xsum(input logic [7:0] q [$], input int from);
        xsum = 8'h00;
        for (int i = from; i < q.size(); i++) xsum ^= q[i];
    endfunction : xsum
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////
    // one request frame, then every reply byte against the expected frames;
    // rn < 0 corrupts the checksum and expects silence
    task automatic req(input logic [7:0] c, input logic [7:0] len, input logic [31:0] p,
                       input logic [7:0] st, input logic [15:0] r, input int rn);
        logic [7:0] q [$];
        logic [7:0] e [$];
        bit ok;
        int w;
        q = {8'h02, c, len, 8'h00};
        for (w = 0; w < len; w++) q.push_back(p[31 - 8 * w -: 8]);
        q.push_back(xsum(q, 0) ^ {7'h00, rn < 0});
        rtm_host_i.got.delete();
        rtm_host_i.send(q, ok);
        chk(16'(ok), 16'h0001);
        e = {8'h02, c | 8'h40, 8'(rn + 1), 8'h00, st};
        if (rn == 2) e = {e, r[15:8], r[7:0]};
        e.push_back(xsum(e, 0));
        if (c == 8'h1D && st == 8'h00) begin
            e = {e, 8'h02, 8'h41, 8'h03, 8'h00, 8'h10, 8'h05, 8'h00};
            e.push_back(xsum(e, 6));
        end
        if (rn < 0) e.delete();
        w = 0;
        while (!(rx_ready === 1'b1 && rtm_host_i.got.size() >= e.size()) && w < 400) begin
            @(negedge clock_in);
            w++;
        end
        repeat (20) @(negedge clock_in);
        if (w >= 400) begin
            bad_count++;
            give_verdict();
        end
        chk(rtm_host_i.got.size(), e.size());
        foreach (e[i]) chk(rtm_host_i.got[i], e[i]);
        $display("test %0d done", tn++);
    endtask : req
    ////////////////////////////////////////
    // main sequence: hand-written corners with random channels, lengths and counts
    initial begin
        {rx_count, slow, nrst_in} = '0;
        repeat (20) @(negedge clock_in);
        nrst_in = 1'b1;
        req(8'h1E, 8'h04, 32'h01000000, 8'hFF, 0, 0);
        req(8'h1D, 8'h00, 0, 8'h00, 0, 0);
        chk({test_mode, phy_2m, power}, 16'h0208);
        req(8'h1D, 8'h00, 0, 8'hFF, 0, 0);
        req(8'h1E, 8'h03, 32'h01000000, 8'h01, 0, 0);
        slow = 1'b1;
        ch = 8'(xs() % 40);
        req(8'h1E, 8'h04, {8'h01, ch, 16'h0000}, 8'h00, 16'h0000, 2);
        chk({rx_test, channel}, {1'b1, ch[5:0]});
        chk(freq, 12'h962 + {3'h0, ch, 1'b0});
        req(8'h1E, 8'h04, {8'h02, ch, 16'h1001}, 8'h03, 0, 0);
        rx_count = 15'(xs());
        req(8'h1E, 8'h04, 32'h03000000, 8'h00, {1'b1, rx_count}, 2);
        chk(rx_test, 1'b0);
        for (k = 0; k < 3; k++) begin
            ln = 8'(xs());
            req(8'h1E, 8'h04, {8'h02, ch, ln, 8'(k)}, 8'h00, 0, 2);
            chk({tx_test, tx_len, pattern}, {1'b1, ln, 2'(k)});
            req(8'h1E, 8'h04, 32'h03000000, 8'h00, 16'h8000, 2);
        end
        req(8'h1E, 8'h04, {8'h02, ch, 16'h0003}, 8'h00, 0, 2);
        chk({carrier, channel}, {1'b1, ch[5:0]});
        req(8'h1E, 8'h04, 32'h02FC0203, 8'h00, 0, 2);
        req(8'h1E, 8'h04, 32'h02050203, 8'h00, 16'h0001, 2);
        chk(power, 8'hFC);
        req(8'h1E, 8'h04, 32'h03000000, 8'h00, 16'h8000, 2);
        req(8'h1E, 8'h04, 32'h01280000, 8'h00, 16'h0001, 2);
        req(8'h1E, 8'h04, 32'h00020200, 8'h00, 0, 2);
        chk(phy_2m, 1'b1);
        req(8'h1E, 8'h04, 32'h03000000, 8'h00, 0, -1);
        req(8'h1E, 8'h04, 32'h00000000, 8'h00, 0, 2);
        chk({phy_2m, power}, 16'h0008);
        req(8'h1E, 8'h04, 32'h00020200, 8'h00, 0, 2);
        req(8'h1E, 8'h04, 32'h00020100, 8'h00, 0, 2);
        chk(phy_2m, 1'b0);
        req(8'h1E, 8'h04, {8'h02, ch, 16'h2000}, 8'h00, 0, 2);
        chk({tx_test, pattern}, 16'h0004);
        req(8'h1E, 8'h04, 32'h00020200, 8'h03, 0, 0);
        req(8'h1E, 8'h04, {8'h01, ch, 16'h0000}, 8'h03, 0, 0);
        chk(phy_2m, 1'b0);
        nrst_in = 1'b0;
        @(negedge clock_in);
        nrst_in = 1'b1;
        chk({test_mode, tx_test}, 16'h0000);
        req(8'h1E, 8'h04, 32'h01000000, 8'hFF, 0, 0);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
